// File: dv/core_exec_assertions.sv
`timescale 1ns/100ps
module core_exec_assertions
  import core_exec_pkg::*;
#(
  parameter int STARTUP_CNT = 8
)
(
  input wire logic               clk,
  input wire logic               rst,
  input wire logic [REG_AW-1:0]  reg_addr,
  input wire logic [DATA_W-1:0]  reg_wdata,
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire logic [DATA_W-1:0]  reg_rdata_ff,
  input wire logic               instr_valid,
  input wire logic [INSTR_W-1:0] instr_data,
  input wire logic               instr_ready_ff,
  input wire logic               wake_irq,
  input wire logic               wdt_tick,
  input wire logic               irq_ff,
  input wire logic               flush_ff,
  input wire logic               isr_branch_ff,
  input wire logic               wdt_reset_ff,
  input wire logic               instruction_clock_out_ff,
  input wire logic               sleeping_ff
);
  // ********************************************************
  // Control shadow
  // ********************************************************
  localparam int SU_LO = STARTUP_CNT - 1;
  localparam int SU_HI = STARTUP_CNT + 1;
  logic [DATA_W-1:0] ctrl_ff;
  logic              rc_mode;
  logic              global_irq_enable;
  logic              take;

  always_ff @(posedge clk)
  begin
    if (rst)
      ctrl_ff <= 8'h00;
    else if (reg_wr && reg_addr == OFS_CTRL)
      ctrl_ff <= reg_wdata;
  end

  assign rc_mode = ctrl_ff[1:0] == 2'b11;
  assign global_irq_enable     = ctrl_ff[CTRL_GIE_POS];
  assign take    = instr_valid && instr_ready_ff;

  // ********************************************************
  // Assertions
  // ********************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_wake;
    $rose(wake_irq) && sleeping_ff;
  endsequence

  sequence s_skip_take;
    take && instr_data[INSTR_W-1:MAJOR_LSB] == MAJ_DECSKIP;
  endsequence

  chk_ready_after_rst: assert property ($fell(rst) |=> instr_ready_ff)
    else $error("ready not raised after reset");
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata_ff == 8'h00)
    else $error("read data not zero outside read answer");
  chk_sleep_entry: assert property (take && instr_data == OP_SLEEP |=>
    sleeping_ff && !instr_ready_ff) else $error("sleep not entered");
  chk_xtal_hold: assert property (s_wake ##0 !rc_mode |-> !instr_ready_ff [*4])
    else $error("crystal wake resumed too early");
  chk_xtal_resume: assert property (s_wake ##0 !rc_mode |->
    ##[SU_LO:SU_HI] instr_ready_ff) else $error("crystal wake start-up length wrong");
  chk_rc_resume: assert property (s_wake ##0 rc_mode |-> ##[1:2] instr_ready_ff)
    else $error("rc wake delayed");
  chk_instruction_clock_out_xtal: assert property (!rc_mode && !$past(rc_mode) && !$past(rc_mode, 2)
    |-> !instruction_clock_out_ff) else $error("clock output in crystal mode");
  chk_isr_gie_off: assert property (isr_branch_ff |-> global_irq_enable)
    else $error("branch with global enable clear");
  chk_flush_cause: assert property (flush_ff |-> $past(take &&
    instr_data[INSTR_W-1:MAJOR_LSB] == MAJ_DECSKIP, 2)) else $error("flush without skip");
  chk_flush_single: assert property (s_skip_take |=> ##1 !flush_ff || !$past(flush_ff))
    else $error("flush pulse held");

endmodule : core_exec_assertions

bind core_exec core_exec_assertions #(.STARTUP_CNT(STARTUP_CNT)) chk_u (
  .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .instr_valid(instr_valid),
  .instr_data(instr_data), .instr_ready_ff(instr_ready_ff), .wake_irq(wake_irq),
  .wdt_tick(wdt_tick), .irq_ff(irq_ff), .flush_ff(flush_ff), .isr_branch_ff(isr_branch_ff),
  .wdt_reset_ff(wdt_reset_ff), .instruction_clock_out_ff(instruction_clock_out_ff),
  .sleeping_ff(sleeping_ff));

// File: dv/core_exec_tb.sv
`timescale 1ns/100ps
module core_exec_tb
  import core_exec_pkg::*;
;
  localparam int SU = 8;
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  logic [REG_AW-1:0]  reg_addr = 3'h0;
  logic [DATA_W-1:0]  reg_wdata = 8'h00;
  logic               reg_wr = 1'b0;
  logic               reg_rd = 1'b0;
  logic               instr_valid = 1'b0;
  logic [INSTR_W-1:0] instr_data = 14'h0000;
  logic               wake_irq = 1'b0;
  logic               wdt_tick = 1'b0;
  logic [DATA_W-1:0]  reg_rdata_ff;
  logic               instr_ready_ff, irq_ff, flush_ff, isr_branch_ff, wdt_reset_ff;
  logic               clk_out, sleeping_ff;
  logic [INSTR_W-1:0] q[$];
  int                 n_fail = 0;
  int                 checked = 0;
  int                 n_flush = 0;
  int                 n_isr = 0;
  int                 n_clk = 0;
  int                 n_wrst = 0;
  int                 n;
  int                 cyc;

  always #5 clk = ~clk;

  core_exec #(.STARTUP_CNT(SU)) dut_u (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .instr_valid(instr_valid),
    .instr_data(instr_data), .instr_ready_ff(instr_ready_ff), .wake_irq(wake_irq),
    .wdt_tick(wdt_tick), .irq_ff(irq_ff), .flush_ff(flush_ff), .isr_branch_ff(isr_branch_ff),
    .wdt_reset_ff(wdt_reset_ff), .instruction_clock_out_ff(clk_out), .sleeping_ff(sleeping_ff));

  // ********************************************************
  // Pulse monitors
  // ********************************************************
  always @(negedge clk)
  begin
    if (flush_ff === 1'b1)
      n_flush++;
    if (isr_branch_ff === 1'b1)
      n_isr++;
    if (clk_out === 1'b1)
      n_clk++;
    if (wdt_reset_ff === 1'b1)
      n_wrst++;
  end

  // ********************************************************
  // Access tasks
  // ********************************************************
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd_chk(input string what, input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(what, exp, reg_rdata_ff);
  endtask : rd_chk

  task automatic run(input logic [13:0] w[$]);
    @(posedge clk);
    foreach (w[i])
    begin
      instr_valid <= 1'b1;
      instr_data <= w[i];
      n = 0;
      do
      begin
        @(posedge clk);
        n++;
      end while (instr_ready_ff !== 1'b1 && n < 50);
      if (instr_ready_ff !== 1'b1)
        n_fail++;
    end
    instr_valid <= 1'b0;
  endtask : run

  task automatic wake;
    @(posedge clk);
    wake_irq <= 1'b1;
    cyc = 0;
    do
    begin
      @(posedge clk);
      cyc++;
    end while (instr_ready_ff !== 1'b1 && cyc < 2000);
    if (instr_ready_ff !== 1'b1)
      n_fail++;
    wake_irq <= 1'b0;
  endtask : wake

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  // ********************************************************
  // Tests
  // ********************************************************
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd_chk("flags", OFS_FLAGS, 8'h03);
    rd_chk("wdt count", OFS_WDT, 8'h00);
    wr(3'h7, 8'h5a);
    rd_chk("unmapped", 3'h7, 8'h00);
    rd_chk("irq clear", OFS_IRQ_CLR, 8'h00);
    $display("test reset done");
    // File memory assumed to power up cleared
    wr(OFS_IRQ_EN, 8'h07);
    run({14'h0390, 14'h0910, 14'h0000});
    rd_chk("w comp", OFS_W, 8'h00);
    rd_chk("zero set kept", OFS_FLAGS, 8'h07);
    run({14'h0310});
    rd_chk("w dec", OFS_W, 8'hfe);
    rd_chk("zero clear", OFS_FLAGS, 8'h03);
    $display("test file ops done");
    q.push_back(14'h09ff);
    repeat (254) q.push_back(14'h03ff);
    q.push_back(14'h0bff);
    q.push_back(14'h0910);
    run(q);
    repeat (3) @(posedge clk);
    rd_chk("w kept", OFS_W, 8'hfe);
    rd_chk("skip flags", OFS_FLAGS, 8'h03);
    rd_chk("irq skip", OFS_IRQ_STAT, 8'h04);
    chk("irq line", 8'h01, {7'h00, irq_ff});
    chk("flush count", 8'h01, 8'(n_flush));
    run({14'h097f});
    rd_chk("f top", OFS_W, 8'hff);
    wr(OFS_IRQ_CLR, 8'h07);
    rd_chk("irq cleared", OFS_IRQ_STAT, 8'h00);
    $display("test skip done");
    wr(OFS_CTRL, 8'h44);
    run({14'h0063});
    rd_chk("sleep flags", OFS_FLAGS, 8'h09);
    wake();
    chk("xtal wake", 8'(SU + 1), 8'(cyc));
    run({14'h0000});
    repeat (4) @(posedge clk);
    chk("isr branch", 8'h01, 8'(n_isr));
    repeat (259)
    begin
      @(posedge clk);
      wdt_tick <= 1'b1;
      @(posedge clk);
      wdt_tick <= 1'b0;
    end
    rd_chk("timeout flags", OFS_FLAGS, 8'h00);
    chk("wdt reset", 8'h01, 8'(n_wrst));
    run({14'h0064});
    rd_chk("clear flags", OFS_FLAGS, 8'h03);
    rd_chk("wdt cleared", OFS_WDT, 8'h00);
    chk("no clock out", 8'h00, 8'(n_clk));
    $display("test crystal wake done");
    wr(OFS_CTRL, 8'h03);
    wr(OFS_IRQ_CLR, 8'h07);
    run({14'h0063});
    wake();
    chk("rc wake", 8'h02, 8'(cyc));
    run({14'h0000});
    repeat (8) @(posedge clk);
    chk("no branch", 8'h01, 8'(n_isr));
    chk("rc clock out", 8'h01, 8'(n_clk != 0));
    $display("test rc wake done");
    end_of_test();
  end

  initial
  begin
    #100000;
    n_fail++;
    end_of_test();
  end

endmodule : core_exec_tb

// File: hw/core_exec.sv
// Notes on behaviour
// - Crystal modes wait 1024 oscillator periods after wake
// - RC mode resumes with no start-up wait
// - Interrupt wake, enable set: branch after next
// - Interrupt wake, enable clear: continue in line
// - No instruction clock output in crystal modes
// - Watchdog clear loads counter zero, one cycle
// - Watchdog clear zeroes prescaler, sets powerdown, sets timeout unless a time-out lands in the same cycle
// - Complement writes inverse, updates zero flag
// - Destination bit: 0 accumulator, 1 file register
// - Decrement writes f minus one, updates zero
// - Seven-bit file address plus destination bit
// - Decrement-skip: no flags, zero discards prefetched instruction other than sleep or watchdog clear
// - Time-out clears timeout bit; sleep clears powerdown
`timescale 1ns/100ps
module core_exec
  import core_exec_pkg::*;
#(
  parameter int STARTUP_CNT = STARTUP_CYCLES
)
(
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic [REG_AW-1:0]  reg_addr,
  input  wire logic [DATA_W-1:0]  reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic      [DATA_W-1:0]  reg_rdata_ff,
  input  wire logic               instr_valid,
  input  wire logic [INSTR_W-1:0] instr_data,
  output logic                    instr_ready_ff,
  input  wire logic               wake_irq,
  input  wire logic               wdt_tick,
  output logic                    irq_ff,
  output logic                    flush_ff,
  output logic                    isr_branch_ff,
  output logic                    wdt_reset_ff,
  output logic                    instruction_clock_out_ff,
  output logic                    sleeping_ff
);

  localparam int SCNT_W = $clog2(STARTUP_CNT + 1);

  pwr_state_t         state_ff;
  pwr_state_t         nxt_state;
  exec_t              ex_ff;
  exec_t              nxt_ex;
  flags_t             flags_ff;
  logic [DATA_W-1:0]  ctrl_ff;
  logic [DATA_W-1:0]  w_ff;
  logic [SCNT_W-1:0]  startup_ff;
  logic               skip_pending_ff;
  logic               isr_pending_ff;
  logic [1:0]         div_ff;
  logic [IRQ_N-1:0]   irq_stat_ff;
  logic [IRQ_N-1:0]   irq_en_ff;
  logic [IRQ_N-1:0]   nxt_irq_stat;
  logic [IRQ_N-1:0]   irq_ev;
  logic [IRQ_N-1:0]   irq_clr;

  logic               accept;
  logic               is_watchdog_clear_op;
  logic               is_sleep;
  logic [MAJOR_W-1:0] major;
  logic [DATA_W-1:0]  operand;
  logic [DATA_W-1:0]  result;
  logic               result_zero;
  logic               skip_now;
  logic               wdt_clear;
  logic               wdt_to;
  logic [WDT_W-1:0]   wdt_count;
  logic               wake;
  logic               crystal;
  logic               global_irq_enable;
  logic               mem_we;

  // ********************************************************
  // Decode
  // ********************************************************
  assign accept    = instr_valid && instr_ready_ff;
  assign is_watchdog_clear_op = accept && (instr_data == OP_WDT_CLEAR);
  assign is_sleep  = accept && (instr_data == OP_SLEEP);
  assign major     = instr_data[INSTR_W-1:MAJOR_LSB];
  assign global_irq_enable       = ctrl_ff[CTRL_GIE_POS];
  assign crystal   = (osc_mode_t'(ctrl_ff[1:0]) != RC_MODE);

  always_comb
  begin
    nxt_ex       = '0;
    nxt_ex.dest  = instr_data[DEST_POS];
    nxt_ex.addr  = instr_data[FADDR_W-1:0];
    nxt_ex.valid = accept && !skip_pending_ff && !skip_now;
    case (major)
      MAJ_COMP:    nxt_ex.kind = OPK_COMP;
      MAJ_DEC:     nxt_ex.kind = OPK_DEC;
      MAJ_DECSKIP: nxt_ex.kind = OPK_DECSKIP;
      default:     nxt_ex.kind = OPK_OTHER;
    endcase
  end

  // ********************************************************
  // File register store
  // ********************************************************
  assign mem_we = ex_ff.valid && (ex_ff.kind != OPK_OTHER) &&
                  (ex_ff.dest == DEST_FILE);

  file_regs #(
    .AW (FADDR_W),
    .DW (DATA_W)
  ) u_file_regs (
    .clk      (clk),
    .we       (mem_we),
    .waddr    (ex_ff.addr),
    .wdata    (result),
    .raddr    (nxt_ex.addr),
    .rdata_ff (operand)
  );

  // ********************************************************
  // Execute
  // ********************************************************
  always_comb
  begin
    result = operand;
    case (ex_ff.kind)
      OPK_COMP:    result = ~operand;
      OPK_DEC:     result = operand - DATA_W'(1);
      OPK_DECSKIP: result = operand - DATA_W'(1);
      default:     result = operand;
    endcase
  end

  assign result_zero = (result == '0);
  assign skip_now    = ex_ff.valid && (ex_ff.kind == OPK_DECSKIP) &&
                       result_zero;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ex_ff <= '0;
    end
    else
    begin
      ex_ff <= nxt_ex;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      w_ff <= '0;
    end
    else if (ex_ff.valid && (ex_ff.kind != OPK_OTHER) &&
             (ex_ff.dest == DEST_W_ACC))
    begin
      w_ff <= result;
    end
  end

  // ********************************************************
  // Skip of prefetched instruction
  // ********************************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      skip_pending_ff <= 1'b0;
      flush_ff        <= 1'b0;
    end
    else
    begin
      flush_ff <= skip_now;
      if (skip_now && !accept)
      begin
        skip_pending_ff <= 1'b1;
      end
      else if (accept)
      begin
        skip_pending_ff <= 1'b0;
      end
    end
  end

  // ********************************************************
  // Status flags
  // ********************************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      flags_ff <= FLAGS_RST;
    end
    else
    begin
      if (ex_ff.valid &&
          ((ex_ff.kind == OPK_COMP) || (ex_ff.kind == OPK_DEC)))
      begin
        flags_ff.zero <= result_zero;
      end
      if (is_watchdog_clear_op)
      begin
        flags_ff.timeout_status_bit <= 1'b1;
        flags_ff.powerdown_flag     <= 1'b1;
      end
      if (is_sleep)
      begin
        flags_ff.powerdown_flag     <= 1'b0;
        flags_ff.timeout_status_bit <= 1'b1;
      end
      if (wdt_to)
      begin
        flags_ff.timeout_status_bit <= 1'b0;
      end
    end
  end

  // ********************************************************
  // Watchdog
  // ********************************************************
  assign wdt_clear = is_watchdog_clear_op || is_sleep || wake;

  watchdog_counter u_watchdog_counter (
    .clk        (clk),
    .rst        (rst),
    .tick       (wdt_tick),
    .clear      (wdt_clear),
    .enable     (ctrl_ff[CTRL_WDTE_POS]),
    .presc_sel  (ctrl_ff[CTRL_PSEL_LSB +: PSEL_W]),
    .count_ff   (wdt_count),
    .timeout_ff (wdt_to)
  );

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wdt_reset_ff <= 1'b0;
    end
    else
    begin
      wdt_reset_ff <= wdt_to && (state_ff == ST_RUN);
    end
  end

  // ********************************************************
  // Power-down and wake-up sequencing
  // ********************************************************
  assign wake = (state_ff == ST_SLEEP) && (wake_irq || wdt_to);

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_RUN:
      begin
        if (is_sleep)
        begin
          nxt_state = ST_SLEEP;
        end
      end
      ST_SLEEP:
      begin
        if (wake)
        begin
          nxt_state = crystal ? ST_STARTUP : ST_RUN;
        end
      end
      ST_STARTUP:
      begin
        if (startup_ff == '0)
        begin
          nxt_state = ST_RUN;
        end
      end
      default: nxt_state = ST_RUN;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_ff       <= ST_RUN;
      instr_ready_ff <= 1'b0;
      sleeping_ff    <= 1'b0;
    end
    else
    begin
      state_ff       <= nxt_state;
      instr_ready_ff <= (nxt_state == ST_RUN);
      sleeping_ff    <= (nxt_state == ST_SLEEP);
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      startup_ff <= '0;
    end
    else if (wake)
    begin
      startup_ff <= SCNT_W'(STARTUP_CNT - 2);
    end
    else if ((state_ff == ST_STARTUP) && (startup_ff != '0))
    begin
      startup_ff <= startup_ff - SCNT_W'(1);
    end
  end

  // ********************************************************
  // Branch to service routine after wake
  // ********************************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      isr_pending_ff <= 1'b0;
      isr_branch_ff  <= 1'b0;
    end
    else
    begin
      isr_branch_ff <= isr_pending_ff && ex_ff.valid;
      if (wake && wake_irq && global_irq_enable)
      begin
        isr_pending_ff <= 1'b1;
      end
      else if (ex_ff.valid)
      begin
        isr_pending_ff <= 1'b0;
      end
    end
  end

  // ********************************************************
  // Instruction clock output
  // ********************************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      div_ff                   <= '0;
      instruction_clock_out_ff <= 1'b0;
    end
    else
    begin
      div_ff                   <= div_ff + 2'(1);
      instruction_clock_out_ff <= !crystal && (state_ff != ST_SLEEP) &&
                                  div_ff[1];
    end
  end

  // ********************************************************
  // Interrupt status, enable and clear
  // ********************************************************
  always_comb
  begin
    irq_ev               = '0;
    irq_ev[IRQ_WDT_TO]   = wdt_to;
    irq_ev[IRQ_WAKE]     = wake;
    irq_ev[IRQ_SKIP]     = skip_now;
    irq_clr              = '0;
    if (reg_wr && (reg_addr == OFS_IRQ_CLR))
    begin
      irq_clr = reg_wdata[IRQ_N-1:0];
    end
    nxt_irq_stat = (irq_stat_ff & ~irq_clr) | irq_ev;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      irq_stat_ff <= '0;
      irq_ff      <= 1'b0;
    end
    else
    begin
      irq_stat_ff <= nxt_irq_stat;
      irq_ff      <= |(nxt_irq_stat & irq_en_ff);
    end
  end

  // ********************************************************
  // Register writes
  // ********************************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ctrl_ff   <= CTRL_RST;
      irq_en_ff <= '0;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        OFS_CTRL:   ctrl_ff   <= reg_wdata;
        OFS_IRQ_EN: irq_en_ff <= reg_wdata[IRQ_N-1:0];
        default:    ctrl_ff   <= ctrl_ff;
      endcase
    end
  end

  // ********************************************************
  // Register reads
  // ********************************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      reg_rdata_ff <= '0;
    end
    else if (reg_rd)
    begin
      case (reg_addr)
        OFS_CTRL:     reg_rdata_ff <= ctrl_ff;
        OFS_FLAGS:    reg_rdata_ff <= DATA_W'({state_ff, flags_ff});
        OFS_W:        reg_rdata_ff <= w_ff;
        OFS_WDT:      reg_rdata_ff <= wdt_count;
        OFS_IRQ_STAT: reg_rdata_ff <= DATA_W'(irq_stat_ff);
        OFS_IRQ_EN:   reg_rdata_ff <= DATA_W'(irq_en_ff);
        default:      reg_rdata_ff <= '0;
      endcase
    end
    else
    begin
      reg_rdata_ff <= '0;
    end
  end

endmodule : core_exec

// File: hw/core_exec_pkg.sv
package core_exec_pkg;

  // ********************************************************
  // Widths
  // ********************************************************
  localparam int DATA_W  = 8;
  localparam int FADDR_W = 7;
  localparam int INSTR_W = 14;
  localparam int MAJOR_W = 6;
  localparam int REG_AW  = 3;
  localparam int WDT_W   = 8;
  localparam int PRESC_W = 7;
  localparam int PSEL_W  = 3;

  // ********************************************************
  // Instruction encodings and fields
  // ********************************************************
  localparam logic [INSTR_W-1:0] OP_WDT_CLEAR = 14'h0064;
  localparam logic [INSTR_W-1:0] OP_SLEEP     = 14'h0063;
  localparam logic [MAJOR_W-1:0] MAJ_COMP     = 6'h09;
  localparam logic [MAJOR_W-1:0] MAJ_DEC      = 6'h03;
  localparam logic [MAJOR_W-1:0] MAJ_DECSKIP  = 6'h0b;
  localparam int                 DEST_POS     = 7;
  localparam int                 MAJOR_LSB    = 8;
  localparam logic               DEST_W_ACC   = 1'b0;
  localparam logic               DEST_FILE    = 1'b1;

  // ********************************************************
  // Timing
  // ********************************************************
  localparam int OSC_STARTUP_PERIODS = 1024;
  localparam int OSC_PERIOD_NS       = 10;
  localparam int CLK_PERIOD_NS       = 10;
  localparam int STARTUP_CYCLES      =
    (OSC_STARTUP_PERIODS * OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ********************************************************
  // Register map and fields
  // ********************************************************
  localparam logic [REG_AW-1:0] OFS_CTRL     = 3'h0;
  localparam logic [REG_AW-1:0] OFS_FLAGS    = 3'h1;
  localparam logic [REG_AW-1:0] OFS_W        = 3'h2;
  localparam logic [REG_AW-1:0] OFS_WDT      = 3'h3;
  localparam logic [REG_AW-1:0] OFS_IRQ_STAT = 3'h4;
  localparam logic [REG_AW-1:0] OFS_IRQ_EN   = 3'h5;
  localparam logic [REG_AW-1:0] OFS_IRQ_CLR  = 3'h6;

  localparam logic [DATA_W-1:0] CTRL_RST     = 8'h00;
  localparam logic [DATA_W-1:0] WDT_CLEARED  = 8'h00;
  localparam logic [PRESC_W-1:0] PRESC_CLEARED = 7'h00;
  localparam int CTRL_GIE_POS  = 2;
  localparam int CTRL_PSEL_LSB = 3;
  localparam int CTRL_WDTE_POS = 6;

  localparam int IRQ_N         = 3;
  localparam int IRQ_WDT_TO    = 0;
  localparam int IRQ_WAKE      = 1;
  localparam int IRQ_SKIP      = 2;

  // ********************************************************
  // Types
  // ********************************************************
  typedef enum logic [1:0] {
    LOW_POWER_CRYSTAL_MODE  = 2'b00,
    STANDARD_CRYSTAL_MODE   = 2'b01,
    HIGH_SPEED_CRYSTAL_MODE = 2'b10,
    RC_MODE                 = 2'b11
  } osc_mode_t;

  typedef enum logic [1:0] {
    ST_RUN     = 2'b00,
    ST_SLEEP   = 2'b01,
    ST_STARTUP = 2'b10
  } pwr_state_t;

  typedef enum logic [2:0] {
    OPK_OTHER   = 3'b000,
    OPK_COMP    = 3'b001,
    OPK_DEC     = 3'b010,
    OPK_DECSKIP = 3'b011
  } op_kind_t;

  typedef struct packed {
    logic               valid;
    op_kind_t           kind;
    logic               dest;
    logic [FADDR_W-1:0] addr;
  } exec_t;

  typedef struct packed {
    logic zero;
    logic powerdown_flag;
    logic timeout_status_bit;
  } flags_t;

  localparam flags_t FLAGS_RST = '{zero: 1'b0, powerdown_flag: 1'b1,
                                   timeout_status_bit: 1'b1};

endpackage : core_exec_pkg

// File: hw/file_regs.sv
`timescale 1ns/100ps
module file_regs
  import core_exec_pkg::*;
#(
  parameter int AW = FADDR_W,
  parameter int DW = DATA_W
)
(
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata_ff
);

  // Cleared at power-up so a fresh part reads zero
  logic [DW-1:0] mem [0:(1<<AW)-1] = '{default: '0};

  // ********************************************************
  // Write port
  // ********************************************************
  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end

  // ********************************************************
  // Registered read, new data on same-address write
  // ********************************************************
  always_ff @(posedge clk)
  begin
    if (we && (waddr == raddr))
    begin
      rdata_ff <= wdata;
    end
    else
    begin
      rdata_ff <= mem[raddr];
    end
  end

endmodule : file_regs

// File: hw/watchdog_counter.sv
`timescale 1ns/100ps
module watchdog_counter
  import core_exec_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              tick,
  input  wire logic              clear,
  input  wire logic              enable,
  input  wire logic [PSEL_W-1:0] presc_sel,
  output logic      [WDT_W-1:0]  count_ff,
  output logic                   timeout_ff
);

  logic [PRESC_W-1:0] presc_ff;
  logic [PRESC_W:0]   one_hot;
  logic [PRESC_W:0]   mask_full;

  assign one_hot   = (PRESC_W+1)'(1) << presc_sel;
  assign mask_full = one_hot - (PRESC_W+1)'(1);

  // ********************************************************
  // Prescaler and counter
  // ********************************************************
  always_ff @(posedge clk)
  begin
    timeout_ff <= 1'b0;
    if (rst || clear)
    begin
      count_ff <= WDT_CLEARED;
      presc_ff <= PRESC_CLEARED;
    end
    else if (enable && tick)
    begin
      if (presc_ff == mask_full[PRESC_W-1:0])
      begin
        presc_ff   <= PRESC_CLEARED;
        count_ff   <= count_ff + WDT_W'(1);
        timeout_ff <= &count_ff;
      end
      else
      begin
        presc_ff <= presc_ff + PRESC_W'(1);
      end
    end
  end

endmodule : watchdog_counter
